// ### hdl/synth_config_default_regs.sv
// configuration register bank R3..R7 behind the three-wire serial port
// assumes host shifts msb first, latch rising edge commits the word
//
// Functional notes
// RULE1 - divider field twelve bits, values below three refused
// RULE2 - pump strength equals gain code plus one
// RULE3 - host always writes access bit zero one
// RULE4 - access bits one to three govern R5-R7
// RULE5 - access zero forces default, one accepts writes
// RULE6 - 24-bit word, low four bits select register
// RULE7 - host must program fastlock word every initialization
// RULE8 - fastlock word reset: dither strong, third order
// RULE9 - doubler, reference_output_enable off; polarities, prescaler set
// RULE10 - extended fraction default zero, code 1011
// RULE11 - timeout word default zero, code 1101
// RULE12 - lock word default clears resets, tristates, adjust
// RULE13 - default mode forces every bit of register
// RULE14 - host writes R0-R4, R5-R7 optional
`timescale 1ns/1ns
`default_nettype none
`include "synth_cfg_defs.svh"
module synth_config_default_regs
  import synth_cfg_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           ser_clk,
  input  wire logic           ser_data,
  input  wire logic           ser_latch,
  output var  if_div_word_t   if_div_word,
  output logic [4:0]          pump_strength_steps,
  output var  fastlock_word_t fastlock_word,
  output var  ext_frac_word_t ext_frac_word,
  output var  timeout_word_t  timeout_word,
  output var  lock_rst_word_t lock_rst_word
);

  // ----------------------------------------
  // pin sampling and edge detection
  // ----------------------------------------
  logic [2:0] pins_s;
  logic [2:0] pins_prev_r;
  logic       clk_rise;
  logic       latch_rise;
  logic       data_s;

  pin_sync u_pin_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({ser_latch, ser_data, ser_clk}),
    .sync_out (pins_s)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_prev_r <= 3'h0;
    end else begin
      pins_prev_r <= pins_s;
    end
  end

  // pins idle low and reset low: no false edge after reset
  assign clk_rise   = pins_s[0] & ~pins_prev_r[0];
  assign data_s     = pins_s[1];
  assign latch_rise = pins_s[2] & ~pins_prev_r[2];

  // ----------------------------------------
  // shift register and commit decode
  // ----------------------------------------
  logic [`SC_WORD_W-1:0] shift_r;
  logic [3:0]            word_code;
  logic [11:0]           word_div;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= 24'h000000;
    end else if (clk_rise) begin
      shift_r <= {shift_r[22:0], data_s};
    end
  end

  assign word_code = shift_r[3:0];   // RULE6
  assign word_div  = shift_r[15:4];

  // ----------------------------------------
  // commit decode
  // ----------------------------------------
  function automatic logic commit_hit(input logic rise, input logic [3:0] seen, input logic [3:0] want);
    commit_hit = rise && (seen == want);
  endfunction : commit_hit

  // ----------------------------------------
  // divider, gain and access word
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      if_div_word <= if_div_word_t'(`SC_R3_RESET);
    end else if (commit_hit(latch_rise, word_code, `SC_CODE_IF_DIV)) begin   // RULE6
      // low divider: keep old divider, other fields still land
      if (word_div < `SC_IF_DIV_MIN) begin   // RULE1
        if_div_word <= if_div_word_t'({shift_r[23:16], if_div_word.if_ref_divider, shift_r[3:0]});
      end else begin
        if_div_word <= if_div_word_t'(shift_r);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_strength_steps <= 5'h01;
    end else begin
      pump_strength_steps <= pump_strength(if_div_word.main_pump_gain_code);   // RULE2
    end
  end

  // ----------------------------------------
  // fastlock and modulator word
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fastlock_word <= fastlock_word_t'(`SC_R4_RESET);   // RULE8 RULE9
    end else if (commit_hit(latch_rise, word_code, `SC_CODE_FASTLOCK)) begin
      fastlock_word <= fastlock_word_t'(shift_r);
    end
  end

  // ----------------------------------------
  // optional registers: stored and forced
  // ----------------------------------------
  logic [`SC_WORD_W-1:0] prog5_r;
  logic [`SC_WORD_W-1:0] prog6_r;
  logic [`SC_WORD_W-1:0] prog7_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog5_r <= `SC_R5_DEFAULT;
    end else if (commit_hit(latch_rise, word_code, `SC_CODE_EXT_FRAC) && if_div_word.access[1]) begin   // RULE5 RULE10
      prog5_r <= shift_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog6_r <= `SC_R6_DEFAULT;
    end else if (commit_hit(latch_rise, word_code, `SC_CODE_TIMEOUT) && if_div_word.access[2]) begin   // RULE5 RULE11
      prog6_r <= shift_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog7_r <= `SC_R7_DEFAULT;
    end else if (commit_hit(latch_rise, word_code, `SC_CODE_LOCK_RST) && if_div_word.access[3]) begin   // RULE5
      prog7_r <= shift_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_frac_word <= ext_frac_word_t'(`SC_R5_DEFAULT);
      timeout_word  <= timeout_word_t'(`SC_R6_DEFAULT);
      lock_rst_word <= lock_rst_word_t'(`SC_R7_DEFAULT);
    end else begin
      ext_frac_word <= ext_frac_word_t'(if_div_word.access[1] ? prog5_r : `SC_R5_DEFAULT);   // RULE4 RULE10 RULE13
      timeout_word  <= timeout_word_t'(if_div_word.access[2] ? prog6_r : `SC_R6_DEFAULT);   // RULE4 RULE11 RULE13
      lock_rst_word <= lock_rst_word_t'(if_div_word.access[3] ? prog7_r : `SC_R7_DEFAULT);  // RULE4 RULE12 RULE13
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_div_floor: assert property (if_div_word.if_ref_divider >= `SC_IF_DIV_MIN)   // RULE1
    else $error("divider below three");
  a_div_refused: assert property (latch_rise && word_code == `SC_CODE_IF_DIV && word_div < `SC_IF_DIV_MIN  // RULE1
    |=> $stable(if_div_word.if_ref_divider))
    else $error("low divider value taken");
  a_pump_steps: assert property (##1 pump_strength_steps == 5'($past(if_div_word.main_pump_gain_code)) + 5'h01)  // RULE2
    else $error("pump strength not code plus one");
  a_word_capture: assert property (latch_rise && word_code == `SC_CODE_IF_DIV && word_div >= `SC_IF_DIV_MIN  // RULE6
    |=> if_div_word == $past(shift_r))
    else $error("divider word not captured");
  a_fastlock_capture: assert property (latch_rise && word_code == `SC_CODE_FASTLOCK  // RULE8
    |=> fastlock_word == $past(shift_r))
    else $error("fastlock word not captured");
  a_frac_default: assert property (!if_div_word.access[1] |=> ext_frac_word == `SC_R5_DEFAULT)  // RULE10
    else $error("extended fraction not forced");
  a_timeout_default: assert property (!if_div_word.access[2] |=> timeout_word == `SC_R6_DEFAULT)  // RULE11
    else $error("timeout word not forced");
  a_lock_default: assert property (!if_div_word.access[3] |=> lock_rst_word == `SC_R7_DEFAULT)  // RULE12
    else $error("lock word not forced");
  a_frac_programmed: assert property (if_div_word.access[1] |=> ext_frac_word == $past(prog5_r))  // RULE5
    else $error("extended fraction not programmed");
  a_write_ignored: assert property (latch_rise && word_code == `SC_CODE_EXT_FRAC && !if_div_word.access[1]  // RULE13
    |=> $stable(prog5_r))
    else $error("write taken in default mode");
  a_timeout_programmed: assert property (if_div_word.access[2] |=> timeout_word == $past(prog6_r))  // RULE4
    else $error("timeout word not programmed");
  a_lock_programmed: assert property (if_div_word.access[3] |=> lock_rst_word == $past(prog7_r))  // RULE4
    else $error("lock word not programmed");
  a_timeout_ignored: assert property (latch_rise && word_code == `SC_CODE_TIMEOUT && !if_div_word.access[2]  // RULE5
    |=> $stable(prog6_r))
    else $error("timeout write taken in default mode");
  a_lock_ignored: assert property (latch_rise && word_code == `SC_CODE_LOCK_RST && !if_div_word.access[3]  // RULE5
    |=> $stable(prog7_r))
    else $error("lock write taken in default mode");
  a_shift_in: assert property (clk_rise  // RULE6
    |=> shift_r[0] == $past(data_s) && shift_r[23:1] == $past(shift_r[22:0]))
    else $error("serial bit not shifted in");

  c_div_write:  cover property (latch_rise && word_code == `SC_CODE_IF_DIV);
  c_frac_write: cover property (latch_rise && word_code == `SC_CODE_EXT_FRAC && if_div_word.access[1]);
  c_lock_toggle: cover property (if_div_word.access[3] ##1 !if_div_word.access[3]);
  c_low_refused: cover property (latch_rise && word_code == `SC_CODE_IF_DIV && word_div < `SC_IF_DIV_MIN);
  c_timeout_open: cover property (latch_rise && word_code == `SC_CODE_TIMEOUT && if_div_word.access[2]);

endmodule : synth_config_default_regs
`default_nettype wire

// ### hdl/synth_cfg_defs.svh
// constants for the synthesizer configuration register bank
// assumes inclusion by the bank module only
`ifndef SYNTH_CFG_DEFS_SVH
`define SYNTH_CFG_DEFS_SVH

`define SC_WORD_W        24
`define SC_CODE_IF_DIV   4'h6
`define SC_CODE_FASTLOCK 4'h9
`define SC_CODE_EXT_FRAC 4'hb
`define SC_CODE_TIMEOUT  4'hd
`define SC_CODE_LOCK_RST 4'hf

`define SC_IF_DIV_MIN    12'h003
`define SC_IF_DIV_MAX    12'hfff

`define SC_R3_RESET      24'h100036
`define SC_R4_RESET      24'h22c709
`define SC_R5_DEFAULT    24'h00000b
`define SC_R6_DEFAULT    24'h00000d
`define SC_R7_DEFAULT    24'h00090f

`endif

// ### hdl/synth_cfg_pkg.sv
// types for the synthesizer configuration register bank
// assumes the defs header is on the include path
package synth_cfg_pkg;

  typedef struct packed {
    logic [3:0]  access;
    logic [3:0]  main_pump_gain_code;
    logic [11:0] if_ref_divider;
    logic [3:0]  register_address_code;
  } if_div_word_t;

  typedef struct packed {
    logic       auto_power_up;
    logic [4:0] fixed_hi;
    logic [1:0] spur_dither_level;
    logic [1:0] modulator_order_select;
    logic       fixed_mid;
    logic       reference_doubler_enable;
    logic       reference_output_enable;
    logic       aux_pump_polarity;
    logic       main_pump_polarity;
    logic       aux_prescaler_select;
    logic [3:0] test_lock_output_select;
    logic [3:0] register_address_code;
  } fastlock_word_t;

  typedef struct packed {
    logic [9:0] extended_fraction_denominator;
    logic [9:0] extended_fraction_numerator;
    logic [3:0] register_address_code;
  } ext_frac_word_t;

  typedef struct packed {
    logic [1:0]  cycle_slip_reduction;
    logic [3:0]  fastlock_pump_current;
    logic [13:0] fastlock_timeout_count;
    logic [3:0]  register_address_code;
  } timeout_word_t;

  typedef struct packed {
    logic [9:0] upper_bits;
    logic       lock_detect_divide_adjust;
    logic [4:0] fixed_mid;
    logic       aux_counter_reset;
    logic       main_counter_reset;
    logic       aux_pump_tristate;
    logic       main_pump_tristate;
    logic [3:0] register_address_code;
  } lock_rst_word_t;

  // pump strength in unit steps: code plus one
  function automatic logic [4:0] pump_strength(input logic [3:0] code);
    pump_strength = {1'b0, code} + 5'h01;
  endfunction : pump_strength

endpackage : synth_cfg_pkg

// ### hdl/pin_sync.sv
// two-flop synchroniser for the three serial pins
// assumes pins are asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] async_in,
  output logic      [2:0] sync_out
);
  logic [2:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r   <= 3'h0;
      sync_out <= 3'h0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ### tb/serial_host.sv
// host model driving the three-wire serial programming port
// assumes clk at 50 MHz; one serial clock period is eight clk cycles
`timescale 1ns/1ns
`default_nettype none
module serial_host (
  input  wire logic clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_latch
);
  initial begin
    ser_clk   = 1'b0;
    ser_data  = 1'b0;
    ser_latch = 1'b0;
  end
  // msb first, serial clock idles low between frames
  task automatic send(input logic [23:0] w);
    if (w[3:0] == 4'h6) w[20] = 1'b1;
    for (int i = 23; i >= 0; i--) begin
      ser_data <= w[i];
      repeat (4) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge clk);
      ser_clk <= 1'b0;
    end
    ser_data <= ~w[0];
    repeat (4) @(posedge clk);
    ser_latch <= 1'b1;
    repeat (4) @(posedge clk);
    ser_latch <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : send
endmodule : serial_host
`default_nettype wire

// ### tb/tb_synth_config_default_regs.sv
// self-checking bench for the configuration register bank
// assumes the serial host model drives the three pins
`timescale 1ns/1ns
`default_nettype none
module tb_synth_config_default_regs
  import synth_cfg_pkg::*;
;
  logic           clk, rst_n, ser_clk, ser_data, ser_latch;
  if_div_word_t   if_div_word;
  logic [4:0]     pump_strength_steps;
  fastlock_word_t fastlock_word;
  ext_frac_word_t ext_frac_word;
  timeout_word_t  timeout_word;
  lock_rst_word_t lock_rst_word;
  int             fail_count = 0;
  int             n_checks   = 0;
  int             cycles     = 0;
  logic [15:0]    lfsr_r     = 16'hce66;
  logic [23:0]    dflt [3]   = '{24'h00000b, 24'h00000d, 24'h00090f};
  logic [3:0]     codes [3]  = '{4'hb, 4'hd, 4'hf};

  synth_config_default_regs i_synth_config_default_regs (.clk(clk), .rst_n(rst_n), .ser_clk(ser_clk),
    .ser_data(ser_data), .ser_latch(ser_latch), .if_div_word(if_div_word),
    .pump_strength_steps(pump_strength_steps), .fastlock_word(fastlock_word),
    .ext_frac_word(ext_frac_word), .timeout_word(timeout_word), .lock_rst_word(lock_rst_word));
  serial_host i_serial_host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));

  function automatic logic [23:0] rnd24();
    for (int i = 0; i < 24; i++) begin
      lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    end
    rnd24 = {lfsr_r, lfsr_r[15:8] ^ lfsr_r[7:0]};
  endfunction : rnd24
  function automatic logic [23:0] exp_steps(input logic [3:0] g);
    exp_steps = 24'(g) + 24'h000001;
  endfunction : exp_steps
  function automatic logic [23:0] opt(input int k);
    opt = (k == 0) ? ext_frac_word : (k == 1) ? timeout_word : lock_rst_word;
  endfunction : opt

  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    logic [23:0] v;
    logic [11:0] d;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("reset r4", fastlock_word, 24'h22c709);
    check("reset r3", if_div_word, 24'h100036);
    check("reset steps", 24'(pump_strength_steps), exp_steps(4'h0));
    for (int j = 0; j < 3; j++) check("reset opt", opt(j), dflt[j]);
    $display("test reset done");
    v = rnd24();
    v[3:0] = 4'h9;
    i_serial_host.send(v);
    check("r4 write", fastlock_word, v);
    for (int g = 0; g < 16; g++) begin
      v = rnd24();
      d = (g == 0) ? 12'h003 : (g == 15) ? 12'hfff : v[15:4] | 12'h004;
      i_serial_host.send({4'h1, 4'(g), d, 4'h6});
      check("r3 word", if_div_word, {4'h1, 4'(g), d, 4'h6});
      check("steps", 24'(pump_strength_steps), exp_steps(4'(g)));
    end
    i_serial_host.send({4'h1, 4'h5, 12'h002, 4'h6});
    check("r3 low div", if_div_word, {4'h1, 4'h5, 12'hfff, 4'h6});
    $display("test divider gain done");
    for (int k = 0; k < 3; k++) begin
      v = rnd24();
      v[3:0] = codes[k];
      i_serial_host.send(v);
      check("opt locked", opt(k), dflt[k]);
      i_serial_host.send({4'(2 << k) | 4'h1, 4'h0, 12'h003, 4'h6});
      check("opt dropped", opt(k), dflt[k]);
      i_serial_host.send(v);
      for (int j = 0; j < 3; j++) check("opt open", opt(j), (j == k) ? v : dflt[j]);
    end
    i_serial_host.send({4'h1, 4'h0, 12'h003, 4'h6});
    for (int j = 0; j < 3; j++) check("opt forced", opt(j), dflt[j]);
    $display("test access done");
    results();
  end
endmodule : tb_synth_config_default_regs
`default_nettype wire
